/* pkg/gpio_port_pkg.sv */
// constants, types and state layout of the bidirectional io port
`default_nettype none
package gpio_port_pkg;

  // ==========================================================================
  // widths
  localparam int PORT_W = 8;
  localparam int ADDR_W = 4;
  localparam int CHG_W  = 4;
  localparam int CHG_LO = 4;
  localparam int SLEW_W = 5;
  localparam int ANS_W  = 5;

  typedef logic [PORT_W-1:0] port_t;
  typedef logic [ADDR_W-1:0] addr_t;

  // ==========================================================================
  // register offsets
  localparam addr_t ADDR_PC_LEVELS = 4'h0;
  localparam addr_t ADDR_PC_LATCH  = 4'h1;
  localparam addr_t ADDR_PC_DIR    = 4'h2;
  localparam addr_t ADDR_PB_LEVELS = 4'h3;
  localparam addr_t ADDR_PB_LATCH  = 4'h4;
  localparam addr_t ADDR_PB_DIR    = 4'h5;
  localparam addr_t ADDR_PB_PULLUP = 4'h6;
  localparam addr_t ADDR_PB_CHANGE = 4'h7;
  localparam addr_t ADDR_SLEW      = 4'h8;
  localparam addr_t ADDR_IRQ_STAT  = 4'h9;
  localparam addr_t ADDR_IRQ_MASK  = 4'hA;
  localparam addr_t ADDR_ANALOG    = 4'hB;
  localparam addr_t ADDR_CTRL_TWO  = 4'hC;

  // ==========================================================================
  // reset values
  localparam port_t               DIR_RST    = 8'hFF;
  localparam port_t               LAT_RST    = 8'h00;
  localparam port_t               PU_RST     = 8'h00;
  localparam logic [CHG_W-1:0]    CHG_RST    = 4'h0;
  localparam logic [SLEW_W-1:0]   SLEW_RST   = 5'h00;
  localparam logic [ANS_W-1:0]    ANS_ALL    = 5'h1F;
  localparam logic [ANS_W-1:0]    ANS_NONE   = 5'h00;
  localparam logic                PU_OFF_RST = 1'b1;

  // ==========================================================================
  // field and pin positions
  localparam int PU_OFF_BIT   = 7;
  localparam int IRQ_CHG_BIT  = 0;
  localparam int PROG_CLK_PIN = 6;
  localparam int PROG_DAT_PIN = 7;
  localparam int CAP_DEF_PIN  = 1;
  localparam int CAP_ALT_PIN  = 3;
  // port b pin served by each analog select bit
  localparam int ANS_PIN [ANS_W] = '{2, 3, 1, 4, 0};

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic  wr;
    logic  rd;
    addr_t addr;
    port_t wdata;
  } reg_req_t;

  typedef struct packed {
    port_t en;
    port_t oe;
    port_t dat;
  } periph_drive_t;

  typedef struct packed {
    port_t             pc_sync1;
    port_t             pc_sync2;
    port_t             pb_sync1;
    port_t             pb_sync2;
    logic [CHG_W-1:0]  pb_prev;
    port_t             pc_lat;
    port_t             pc_dir;
    port_t             pb_lat;
    port_t             pb_dir;
    port_t             pb_pu_en;
    logic [CHG_W-1:0]  pb_chg_en;
    logic [SLEW_W-1:0] slew;
    logic [ANS_W-1:0]  ans;
    logic              pu_off;
    logic              irq_stat;
    logic              irq_mask;
    port_t             rd_data;
    port_t             pc_out;
    port_t             pc_oe;
    port_t             pb_out;
    port_t             pb_oe;
    port_t             pb_pu;
    port_t             pb_ana;
    logic              cap_in;
    logic              prog_clk;
    logic              prog_dat;
    logic              irq;
  } state_t;

endpackage : gpio_port_pkg
`default_nettype wire

/* rtl/bidirectional_io_port.sv */
// bidirectional io port with peripheral overrides and neighbouring port upper pins
//
// Summary of operation
// - eight pins, each with own direction bit
// - direction one disables driver, pin is input
// - direction zero drives pin from output latch
// - latch register separate, reads return latch
// - relocate bit zero moves capture to alternate
// - relocate bit default one, default pin
// - serial peripherals override port c pin direction
// - reset makes every pin an input, port b pins zero to four analog or digital per analog default bit
// - direction read returns stored bits always
// - analog default bit picks analog reset state
// - program mode disables other program-pin functions
// - program clock taken from pin six
// - pin seven carries bidirectional program data
// - don't-care functions ignore the direction bit
// - per-bit weak pull-ups on port b inputs
// - unimplemented bits read as zero
`timescale 1ns/100ps
`default_nettype none
module bidirectional_io_port
  import gpio_port_pkg::*;
(
  input  wire logic          clk_in,
  input  wire logic          rst_n_in,
  input  wire reg_req_t      reg_req_in,
  output var  port_t         reg_rdata_out,
  input  wire logic          capture_relocate_cfg_in,
  input  wire logic          analog_default_cfg_in,
  input  wire port_t         port_c_pin_in,
  output var  port_t         port_c_pin_out,
  output var  port_t         port_c_pin_oe_out,
  input  wire port_t         port_b_pin_in,
  output var  port_t         port_b_pin_out,
  output var  port_t         port_b_pin_oe_out,
  output var  port_t         port_b_pullup_out,
  output var  port_t         port_b_analog_out,
  input  wire periph_drive_t serial_comm_peripheral_in,
  input  wire periph_drive_t sync_serial_peripheral_in,
  input  wire logic          capture_compare_two_drive_in,
  input  wire logic          capture_compare_two_data_in,
  output var  logic          capture_compare_two_out,
  input  wire logic          program_mode_in,
  input  wire logic          program_data_oe_in,
  input  wire logic          program_data_in,
  output var  logic          program_clock_pin_out,
  output var  logic          program_data_pin_out,
  output var  logic          irq_out
);

  // ==========================================================================
  // helpers
  function automatic port_t ans_to_pins(input logic [ANS_W-1:0] ans);
    port_t pins;
    pins = '0;
    for (int i = 0; i < ANS_W; i++)
    begin
      pins[ANS_PIN[i]] = ans[i];
    end
    return pins;
  endfunction

  // driver enable is the inverse of the direction bit
  function automatic port_t drive_enable(input port_t dir);
    return ~dir;
  endfunction

  // ==========================================================================
  // register bus decode
  function automatic logic bus_hit(input logic strobe, input addr_t addr, input addr_t target);
    return strobe && (addr == target);
  endfunction

  // write one to clear on the status register
  function automatic logic status_clear(input reg_req_t req);
    return bus_hit(req.wr, req.addr, ADDR_IRQ_STAT) && req.wdata[IRQ_CHG_BIT];
  endfunction

  // stores one written byte into the register image
  function automatic state_t write_reg(input state_t s, input reg_req_t req);
    state_t n;
    n = s;
    case (req.addr)
      ADDR_PC_LEVELS: n.pc_lat    = req.wdata;
      ADDR_PC_LATCH:  n.pc_lat    = req.wdata;
      ADDR_PC_DIR:    n.pc_dir    = req.wdata;
      ADDR_PB_LEVELS: n.pb_lat    = req.wdata;
      ADDR_PB_LATCH:  n.pb_lat    = req.wdata;
      ADDR_PB_DIR:    n.pb_dir    = req.wdata;
      ADDR_PB_PULLUP: n.pb_pu_en  = req.wdata;
      ADDR_PB_CHANGE: n.pb_chg_en = req.wdata[CHG_LO +: CHG_W];
      ADDR_SLEW:      n.slew      = req.wdata[SLEW_W-1:0];
      ADDR_IRQ_MASK:  n.irq_mask  = req.wdata[IRQ_CHG_BIT];
      ADDR_ANALOG:    n.ans       = req.wdata[ANS_W-1:0];
      ADDR_CTRL_TWO:  n.pu_off    = req.wdata[PU_OFF_BIT];
      default:        n           = s;
    endcase
    return n;
  endfunction

  // ==========================================================================
  // register read mux, unimplemented bits stay zero
  function automatic port_t read_reg(input state_t s, input port_t pb_dig, input addr_t addr);
    port_t r;
    r = '0;
    case (addr)
      ADDR_PC_LEVELS: r = s.pc_sync2;
      ADDR_PC_LATCH:  r = s.pc_lat;
      ADDR_PC_DIR:    r = s.pc_dir;
      ADDR_PB_LEVELS: r = pb_dig;
      ADDR_PB_LATCH:  r = s.pb_lat;
      ADDR_PB_DIR:    r = s.pb_dir;
      ADDR_PB_PULLUP: r = s.pb_pu_en;
      ADDR_PB_CHANGE: r[CHG_LO +: CHG_W] = s.pb_chg_en;
      ADDR_SLEW:      r[SLEW_W-1:0] = s.slew;
      ADDR_IRQ_STAT:  r[IRQ_CHG_BIT] = s.irq_stat;
      ADDR_IRQ_MASK:  r[IRQ_CHG_BIT] = s.irq_mask;
      ADDR_ANALOG:    r[ANS_W-1:0] = s.ans;
      ADDR_CTRL_TWO:  r[PU_OFF_BIT] = s.pu_off;
      default:        r = '0;
    endcase
    return r;
  endfunction

  // ==========================================================================
  // peripheral overrides, later callers win
  function automatic port_t take_oe(input port_t oe, input periph_drive_t p);
    port_t r;
    r = oe;
    for (int i = 0; i < PORT_W; i++)
    begin
      if (p.en[i])
      begin
        r[i] = p.oe[i];
      end
    end
    return r;
  endfunction

  function automatic port_t take_dat(input port_t dat, input periph_drive_t p);
    port_t r;
    r = dat;
    for (int i = 0; i < PORT_W; i++)
    begin
      if (p.en[i])
      begin
        r[i] = p.dat[i];
      end
    end
    return r;
  endfunction

  // ==========================================================================
  // pin change detection on enabled upper input pins
  function automatic logic change_seen(input logic [CHG_W-1:0] en, input port_t dir, input port_t now,
                                       input logic [CHG_W-1:0] prev);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < CHG_W; i++)
    begin
      if (en[i] && dir[CHG_LO + i] && (now[CHG_LO + i] != prev[i]))
      begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  // ==========================================================================
  // weak pull-ups only on digital input pins, off on program pins in program mode
  function automatic port_t pb_pullups(input state_t s, input port_t analog, input logic prog);
    port_t r;
    r = s.pb_pu_en & s.pb_dir & ~analog &
        {PORT_W{~s.pu_off}};
    if (prog)
    begin
      r[PROG_CLK_PIN] = 1'b0;
      r[PROG_DAT_PIN] = 1'b0;
    end
    return r;
  endfunction

  // ==========================================================================
  // capture input from the pin that the relocation bit selects
  function automatic logic capture_pin(input logic reloc, input port_t pc_lvl, input port_t pb_lvl);
    logic r;
    if (reloc)
    begin
      r = pc_lvl[CAP_DEF_PIN];
    end
    else
    begin
      r = pb_lvl[CAP_ALT_PIN];
    end
    return r;
  endfunction

  function automatic state_t reset_state(input logic analog_default);
    state_t s;
    s           = '0;
    s.pc_lat    = LAT_RST;
    s.pc_dir    = DIR_RST;
    s.pb_lat    = LAT_RST;
    s.pb_dir    = DIR_RST;
    s.pb_pu_en  = PU_RST;
    s.pb_chg_en = CHG_RST;
    s.slew      = SLEW_RST;
    s.ans       = analog_default ? ANS_ALL : ANS_NONE;
    s.pu_off    = PU_OFF_RST;
    s.pb_ana    = ans_to_pins(s.ans);
    return s;
  endfunction

  // ==========================================================================
  // state
  state_t state_q;
  state_t state_d;
  port_t  pb_digital;
  port_t  pb_analog_mask;
  port_t  pc_oe_v;
  port_t  pc_out_v;
  port_t  pb_oe_v;
  port_t  pb_out_v;
  logic   chg_event;

  always_comb
  begin
    state_d = state_q;

    // two-flop pin synchronisers
    state_d.pc_sync1 = port_c_pin_in;
    state_d.pc_sync2 = state_q.pc_sync1;
    state_d.pb_sync1 = port_b_pin_in;
    state_d.pb_sync2 = state_q.pb_sync1;

    // analog pins read as zero on the digital path
    pb_analog_mask = ans_to_pins(state_q.ans);
    pb_digital     = state_q.pb_sync2 & ~pb_analog_mask;

    // ========================================================================
    // register writes
    if (reg_req_in.wr)
    begin
      state_d = write_reg(state_d, reg_req_in);
    end

    // ========================================================================
    // port change flag: set wins over write-one-to-clear
    chg_event = change_seen(state_q.pb_chg_en, state_q.pb_dir, pb_digital,
                            state_q.pb_prev);
    if (program_mode_in)
    begin
      // program pins serve only the programmer
      if ((pb_digital[PROG_CLK_PIN] != state_q.pb_prev[PROG_CLK_PIN - CHG_LO]) ||
          (pb_digital[PROG_DAT_PIN] != state_q.pb_prev[PROG_DAT_PIN - CHG_LO]))
      begin
        chg_event = 1'b0;
      end
    end
    state_d.pb_prev = pb_digital[CHG_LO +: CHG_W];
    if (status_clear(reg_req_in))
    begin
      state_d.irq_stat = 1'b0;
    end
    if (chg_event)
    begin
      state_d.irq_stat = 1'b1;
    end
    state_d.irq = state_d.irq_stat & state_d.irq_mask;

    // ========================================================================
    // register reads, data one cycle later
    state_d.rd_data = '0;
    if (reg_req_in.rd)
    begin
      state_d.rd_data = read_reg(state_q, pb_digital, reg_req_in.addr);
    end

    // ========================================================================
    // port c drivers
    pc_oe_v  = drive_enable(state_q.pc_dir);
    pc_out_v = state_q.pc_lat;
    if (capture_relocate_cfg_in && capture_compare_two_drive_in && !state_q.pc_dir[CAP_DEF_PIN])
    begin
      pc_out_v[CAP_DEF_PIN] = capture_compare_two_data_in;
    end
    pc_oe_v  = take_oe(pc_oe_v, sync_serial_peripheral_in);
    pc_out_v = take_dat(pc_out_v, sync_serial_peripheral_in);
    pc_oe_v  = take_oe(pc_oe_v, serial_comm_peripheral_in);
    pc_out_v = take_dat(pc_out_v, serial_comm_peripheral_in);
    state_d.pc_oe  = pc_oe_v;
    state_d.pc_out = pc_out_v;

    // ========================================================================
    // port b drivers
    pb_oe_v  = drive_enable(state_q.pb_dir);
    pb_out_v = state_q.pb_lat;
    if (!capture_relocate_cfg_in && capture_compare_two_drive_in && !state_q.pb_dir[CAP_ALT_PIN])
    begin
      pb_out_v[CAP_ALT_PIN] = capture_compare_two_data_in;
    end
    if (program_mode_in)
    begin
      pb_oe_v[PROG_CLK_PIN]  = 1'b0;
      pb_oe_v[PROG_DAT_PIN]  = program_data_oe_in;
      pb_out_v[PROG_DAT_PIN] = program_data_in;
    end
    state_d.pb_oe  = pb_oe_v;
    state_d.pb_out = pb_out_v;
    state_d.pb_ana = pb_analog_mask;
    state_d.pb_pu  = pb_pullups(state_q, pb_analog_mask, program_mode_in);

    // ========================================================================
    // inputs handed to peripherals
    state_d.cap_in   = capture_pin(capture_relocate_cfg_in, state_q.pc_sync2, pb_digital);
    state_d.prog_clk = program_mode_in & state_q.pb_sync2[PROG_CLK_PIN];
    state_d.prog_dat = program_mode_in & state_q.pb_sync2[PROG_DAT_PIN];
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      state_q <= reset_state(analog_default_cfg_in);
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // ==========================================================================
  // outputs straight from flops
  assign reg_rdata_out           = state_q.rd_data;
  assign port_c_pin_out          = state_q.pc_out;
  assign port_c_pin_oe_out       = state_q.pc_oe;
  assign port_b_pin_out          = state_q.pb_out;
  assign port_b_pin_oe_out       = state_q.pb_oe;
  assign port_b_pullup_out       = state_q.pb_pu;
  assign port_b_analog_out       = state_q.pb_ana;
  assign capture_compare_two_out = state_q.cap_in;
  assign program_clock_pin_out   = state_q.prog_clk;
  assign program_data_pin_out    = state_q.prog_dat;
  assign irq_out                 = state_q.irq;

endmodule // bidirectional_io_port
`default_nettype wire

/* bench/pin_world.sv */
// far-side pin model: device drive, external drive, pull-up, else a toggling float
`timescale 1ns/100ps
`default_nettype none
module pin_world
  import gpio_port_pkg::*;
(
  input  wire logic  clk_in,
  input  wire port_t dev_dat_in,
  input  wire port_t dev_oe_in,
  input  wire port_t pull_in,
  input  wire port_t ext_dat_in,
  input  wire port_t ext_en_in,
  output var  port_t pin_out
);
  port_t float_q = 8'h55;
  // undriven line without pull-up never holds its last value
  always @(posedge clk_in) float_q <= ~float_q;
  assign pin_out = (dev_oe_in & dev_dat_in) | (~dev_oe_in & ext_en_in & ext_dat_in)
    | (~dev_oe_in & ~ext_en_in & (pull_in | float_q));
endmodule // pin_world
`default_nettype wire

/* bench/io_port_properties.sv */
// boundary assertions of the bidirectional io port
`timescale 1ns/100ps
`default_nettype none
module io_port_properties
  import gpio_port_pkg::*;
(
  input wire logic          clk_in,
  input wire logic          rst_n_in,
  input wire reg_req_t      reg_req_in,
  input wire port_t         reg_rdata_out,
  input wire logic          capture_relocate_cfg_in,
  input wire logic          analog_default_cfg_in,
  input wire port_t         port_c_pin_in,
  input wire port_t         port_c_pin_oe_out,
  input wire port_t         port_b_pin_in,
  input wire port_t         port_b_pin_out,
  input wire port_t         port_b_pin_oe_out,
  input wire port_t         port_b_pullup_out,
  input wire port_t         port_b_analog_out,
  input wire periph_drive_t serial_comm_peripheral_in,
  input wire logic          capture_compare_two_out,
  input wire logic          program_mode_in,
  input wire logic          program_data_oe_in,
  input wire logic          program_data_in,
  input wire logic          program_clock_pin_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // ==========================================================================
  // properties
  chk_rdata_idle: assert property (!$past(reg_req_in.rd) |-> reg_rdata_out == 8'h00)
    else $error("read data not zero outside read cycle");
  chk_reset_inputs: assert property ($past(!rst_n_in) && $past(!rst_n_in, 2)
    |-> (port_c_pin_oe_out | port_b_pin_oe_out | port_b_pullup_out) == 8'h00)
    else $error("pins not plain inputs after reset");
  chk_analog_reset: assert property ($past(!rst_n_in) && $past(!rst_n_in, 2)
    |-> port_b_analog_out == (analog_default_cfg_in ? 8'h1F : 8'h00))
    else $error("analog state after reset wrong");
  chk_serial_override: assert property ($past(|serial_comm_peripheral_in.en) |->
    ((port_c_pin_oe_out ^ $past(serial_comm_peripheral_in.oe)) & $past(serial_comm_peripheral_in.en)) == 8'h00)
    else $error("serial override direction not applied");
  chk_clock_pin_quiet: assert property (!$past(program_mode_in) |-> !program_clock_pin_out)
    else $error("program clock seen outside program mode");
  chk_clock_pin_undriven: assert property ($past(program_mode_in) |-> !port_b_pin_oe_out[6])
    else $error("program clock pin driven");
  chk_data_pin_drive: assert property ($past(program_mode_in) |-> port_b_pin_oe_out[7] == $past(program_data_oe_in)
    && (!port_b_pin_oe_out[7] || port_b_pin_out[7] == $past(program_data_in)))
    else $error("program data pin drive wrong");
  chk_clock_pin_follow: assert property ((rst_n_in && program_mode_in && $stable(port_b_pin_in[6]))[*4]
    |-> program_clock_pin_out == port_b_pin_in[6])
    else $error("program clock does not follow pin six");
  chk_capture_route: assert property ((rst_n_in && $stable(capture_relocate_cfg_in) && $stable(port_c_pin_in[1])
    && $stable(port_b_pin_in[3]))[*5] |-> capture_compare_two_out ==
    (capture_relocate_cfg_in ? port_c_pin_in[1] : port_b_pin_in[3]))
    else $error("capture input taken from wrong pin");
endmodule // io_port_properties
bind bidirectional_io_port io_port_properties chk_u (.clk_in, .rst_n_in, .reg_req_in, .reg_rdata_out,
  .capture_relocate_cfg_in, .analog_default_cfg_in, .port_c_pin_in, .port_c_pin_oe_out, .port_b_pin_in,
  .port_b_pin_out, .port_b_pin_oe_out, .port_b_pullup_out, .port_b_analog_out, .serial_comm_peripheral_in,
  .capture_compare_two_out, .program_mode_in, .program_data_oe_in, .program_data_in, .program_clock_pin_out);
`default_nettype wire

/* bench/bidirectional_io_port_bench.sv */
// register-level bench of the bidirectional io port
`timescale 1ns/100ps
`default_nettype none
module bidirectional_io_port_bench;
  import gpio_port_pkg::*;
  logic          clk_in = 1'b0;
  logic          rst_n_in = 1'b0;
  reg_req_t      req = '0;
  logic          reloc = 1'b1, ana_cfg = 1'b1, pmode = 1'b0, pd_oe = 1'b0, pd = 1'b0, cc_drv = 1'b0, cc_dat = 1'b0;
  periph_drive_t sc = '0, ss = '0;
  port_t         ext_c_en = 8'hFF, ext_c = 8'h00, ext_b_en = 8'hFF, ext_b = 8'h00;
  port_t         c_in, c_out, c_oe, b_in, b_out, b_oe, b_pu, b_ana, rdata;
  logic          cap, pclk, pdat, irq;
  int            miscompares = 0, checked = 0;
  always #5 clk_in = ~clk_in;
  bidirectional_io_port dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .reg_req_in(req), .reg_rdata_out(rdata),
    .capture_relocate_cfg_in(reloc), .analog_default_cfg_in(ana_cfg), .port_c_pin_in(c_in), .port_c_pin_out(c_out),
    .port_c_pin_oe_out(c_oe), .port_b_pin_in(b_in), .port_b_pin_out(b_out), .port_b_pin_oe_out(b_oe),
    .port_b_pullup_out(b_pu), .port_b_analog_out(b_ana), .serial_comm_peripheral_in(sc),
    .sync_serial_peripheral_in(ss), .capture_compare_two_drive_in(cc_drv), .capture_compare_two_data_in(cc_dat),
    .capture_compare_two_out(cap), .program_mode_in(pmode), .program_data_oe_in(pd_oe), .program_data_in(pd),
    .program_clock_pin_out(pclk), .program_data_pin_out(pdat), .irq_out(irq));
  pin_world c_side_u (.clk_in(clk_in), .dev_dat_in(c_out), .dev_oe_in(c_oe), .pull_in(8'h00),
    .ext_dat_in(ext_c), .ext_en_in(ext_c_en), .pin_out(c_in));
  pin_world b_side_u (.clk_in(clk_in), .dev_dat_in(b_out), .dev_oe_in(b_oe), .pull_in(b_pu),
    .ext_dat_in(ext_b), .ext_en_in(ext_b_en), .pin_out(b_in));
  // ==========================================================================
  // tasks
  task automatic cmp(input port_t got, input port_t exp);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] time %0t got 0x%h expected 0x%h", $time, got, exp);
    end
  endtask
  task automatic wr(input addr_t a, input port_t d);
    @(posedge clk_in);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_in);
    req <= '0;
  endtask
  task automatic rd(input addr_t a, input port_t exp);
    @(posedge clk_in);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_in);
    req <= '0;
    #1 cmp(rdata, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    #200000;
    miscompares++;
    wrap_up();
  end
  // ==========================================================================
  // tests
  initial
  begin
    tick(6);
    rst_n_in <= 1'b1;
    tick(1);
    cmp(c_oe | b_oe, 8'h00);
    cmp(b_ana, 8'h1F);
    rd(ADDR_PC_DIR, 8'hFF);
    rd(ADDR_PB_DIR, 8'hFF);
    rd(ADDR_CTRL_TWO, 8'h80);
    rd(4'hD, 8'h00);
    wr(ADDR_PB_CHANGE, 8'hFF);
    rd(ADDR_PB_CHANGE, 8'hF0);
    wr(ADDR_SLEW, 8'hFF);
    rd(ADDR_SLEW, 8'h1F);
    $display("reset test done");
    wr(ADDR_PC_DIR, 8'h0F);
    wr(ADDR_PC_LEVELS, 8'hA5);
    ext_c_en <= 8'h0F;
    ext_c <= 8'h03;
    tick(3);
    cmp(c_oe, 8'hF0);
    cmp(c_out & c_oe, 8'hA0);
    rd(ADDR_PC_LATCH, 8'hA5);
    rd(ADDR_PC_LEVELS, 8'hA3);
    wr(ADDR_PC_DIR, 8'hFF);
    ext_c_en <= 8'hFF;
    ext_c <= 8'h3C;
    tick(3);
    rd(ADDR_PC_LEVELS, 8'h3C);
    rd(ADDR_PC_LATCH, 8'hA5);
    sc <= '{en: 8'h40, oe: 8'h40, dat: 8'h40};
    ss <= '{en: 8'h48, oe: 8'h08, dat: 8'h08};
    tick(2);
    cmp(c_oe, 8'h48);
    cmp(c_out & c_oe, 8'h48);
    rd(ADDR_PC_DIR, 8'hFF);
    sc <= '0;
    ss <= '0;
    $display("port c test done");
    wr(ADDR_ANALOG, 8'h00);
    ext_c <= 8'h02;
    tick(5);
    cmp({7'h00, cap}, 8'h01);
    reloc <= 1'b0;
    ext_b <= 8'h08;
    tick(5);
    cmp({7'h00, cap}, 8'h01);
    ext_b <= 8'h00;
    tick(5);
    cmp({7'h00, cap}, 8'h00);
    reloc <= 1'b1;
    wr(ADDR_PC_DIR, 8'hFD);
    cc_drv <= 1'b1;
    cc_dat <= 1'b1;
    tick(2);
    cmp(c_out & c_oe, 8'h02);
    reloc <= 1'b0;
    wr(ADDR_PB_DIR, 8'hF7);
    tick(2);
    cmp(b_out & b_oe, 8'h08);
    wr(ADDR_PB_DIR, 8'hFF);
    reloc <= 1'b1;
    cc_drv <= 1'b0;
    $display("capture test done");
    wr(ADDR_CTRL_TWO, 8'h00);
    wr(ADDR_PB_PULLUP, 8'hFF);
    wr(ADDR_PB_DIR, 8'h0F);
    tick(2);
    cmp(b_pu, 8'h0F);
    rd(ADDR_PB_PULLUP, 8'hFF);
    cmp(b_ana, 8'h00);
    wr(ADDR_PB_DIR, 8'hFF);
    wr(ADDR_IRQ_MASK, 8'h01);
    wr(ADDR_IRQ_STAT, 8'h01);
    rd(ADDR_IRQ_STAT, 8'h00);
    ext_b <= 8'h20;
    tick(5);
    cmp({7'h00, irq}, 8'h01);
    rd(ADDR_IRQ_STAT, 8'h01);
    wr(ADDR_IRQ_STAT, 8'h01);
    tick(2);
    cmp({7'h00, irq}, 8'h00);
    ext_b <= 8'h21;
    tick(5);
    rd(ADDR_IRQ_STAT, 8'h00);
    wr(ADDR_IRQ_MASK, 8'h00);
    rd(ADDR_IRQ_MASK, 8'h00);
    ext_b <= 8'hA1;
    tick(5);
    cmp({7'h00, irq}, 8'h00);
    rd(ADDR_IRQ_STAT, 8'h01);
    rd(ADDR_PB_LEVELS, 8'hA1);
    wr(ADDR_ANALOG, 8'h10);
    rd(ADDR_PB_LEVELS, 8'hA0);
    wr(ADDR_ANALOG, 8'h00);
    $display("pull-up and change test done");
    pmode <= 1'b1;
    pd_oe <= 1'b1;
    pd <= 1'b1;
    ext_b_en <= 8'h7F;
    ext_b <= 8'h40;
    tick(4);
    cmp(b_pu & 8'hC0, 8'h00);
    cmp({6'h00, pclk, pdat}, 8'h03);
    wr(ADDR_PB_DIR, 8'h00);
    tick(2);
    cmp(b_oe & 8'hC0, 8'h80);
    cmp(b_out & 8'h80, 8'h80);
    pd_oe <= 1'b0;
    ext_b_en <= 8'hFF;
    ext_b <= 8'h00;
    tick(4);
    cmp({6'h00, pclk, pdat}, 8'h00);
    pmode <= 1'b0;
    ana_cfg <= 1'b0;
    rst_n_in <= 1'b0;
    tick(3);
    rst_n_in <= 1'b1;
    tick(1);
    cmp(b_ana, 8'h00);
    rd(ADDR_PB_DIR, 8'hFF);
    $display("program and second reset test done");
    wrap_up();
  end
endmodule // bidirectional_io_port_bench
`default_nettype wire
